// [include/irq_defines.svh]
// Register offsets, field positions, reset values and sizes of the irq block
`ifndef IRQ_DEFINES_SVH
`define IRQ_DEFINES_SVH

// Register byte offsets
`define OFF_IRQ_EN       8'h00
`define OFF_IRQ_FLAG     8'h04
`define OFF_STATUS_ONE   8'h08
`define OFF_ERROR        8'h0c
`define OFF_FIFO_LEVEL   8'h10
`define OFF_WATERMARK    8'h14
`define OFF_TIMER_MODE   8'h18
`define OFF_TIMER_RELOAD 8'h1c
`define OFF_TIMER_VALUE  8'h20
`define OFF_CONTROL      8'h24
`define OFF_COMMAND      8'h28

// Interrupt flag bit positions
`define FLG_TIMER   0
`define FLG_ERROR   1
`define FLG_A_EMPTY 2
`define FLG_A_FULL  3
`define FLG_IDLE    4
`define FLG_RX      5
`define FLG_TX      6
`define FLG_CRC     7
`define FLG_CARD    8
`define FLG_FOREIGN 9
`define FLG_RF_LOW  10
`define FLG_OSC     11
`define FLG_WDT     12
`define FLG_COUNT   13
`define FLG_SET_SEL 31

// Other field positions
`define ST_A_EMPTY  0
`define ST_A_FULL   1
`define ST_RUNNING  3
`define ST_IRQ      4
`define ST_CRC_RDY  5
`define FIFO_FLUSH  7
`define TM_AUTO     12
`define TM_PERIODIC 13
`define TM_EVEN     14
`define CTL_START   0
`define CTL_STOP    1

// Sizes and reset values
`define FIFO_DEPTH      7'd64
`define WATERMARK_RST   6'h08
`define CMD_IDLE        4'h0
`define PRESCALE_RST    12'h000
`define RELOAD_RST      16'h0000

`endif

// [include/irq_pkg.sv]
// Types shared by the irq block and its timer
package irq_pkg;
  typedef logic [12:0] irq_vec_t;
  typedef enum logic [0:0] {
    TMR_STOPPED = 1'b0,
    TMR_COUNTING = 1'b1
  } tmr_state_e;
endpackage : irq_pkg

// [include/timer_if.sv]
// Control and status bundle between register block and timer
`timescale 1ns/100ps
interface timer_if;
  logic        start_now;
  logic        stop_now;
  logic        auto_evt;
  logic        auto_en;
  logic        periodic;
  logic        even_sel;
  logic [11:0] prescale_reload;
  logic [15:0] counter_reload;
  logic        running;
  logic [15:0] value;
  logic        expired;
  modport ctl (output start_now, stop_now, auto_evt, auto_en, periodic, even_sel,
               output prescale_reload, counter_reload, input running, value, expired);
  modport core (input start_now, stop_now, auto_evt, auto_en, periodic, even_sel,
                input prescale_reload, counter_reload, output running, value, expired);
endinterface : timer_if

// [src/irq_timer_core.sv]
// Prescaled down-counting timer
`timescale 1ns/100ps
`include "irq_defines.svh"
module irq_timer_core
  import irq_pkg::*;
(
  input  wire logic clk_in,
  input  wire logic resetn_in,
  timer_if.core     tif
);

  tmr_state_e  state_reg;
  logic [12:0] pre_cnt_reg;
  logic [15:0] cnt_reg;
  logic        expired_reg;
  logic        hold_reg;
  logic [12:0] pre_top;
  logic        tick;
  logic        start;

  // prescale stage divides by 2P+1, or 2P+2 when even
  assign pre_top = {tif.prescale_reload, tif.even_sel};
  assign tick    = (state_reg == TMR_COUNTING) && (pre_cnt_reg == 13'h0000);
  // manual start or protocol event in auto mode
  assign start   = tif.start_now || (tif.auto_en && tif.auto_evt);

  // State, prescaler and counter; stop wins over start
  always_ff @(posedge clk_in)
  begin
    if (!resetn_in)
    begin
      state_reg   <= TMR_STOPPED;
      pre_cnt_reg <= 13'h0000;
      cnt_reg     <= `RELOAD_RST;
    end
    else if (tif.stop_now)
      state_reg <= TMR_STOPPED;
    else if (start)
    begin
      state_reg   <= TMR_COUNTING;
      pre_cnt_reg <= pre_top;
      cnt_reg     <= tif.counter_reload;
    end
    else if (tick)
    begin
      pre_cnt_reg <= pre_top;
      // stop at zero or restart from reload
      case (state_reg)
        TMR_COUNTING:
        begin
          if (hold_reg)
            cnt_reg <= tif.counter_reload;
          else if ((cnt_reg == 16'h0000) && tif.periodic)
            cnt_reg <= tif.counter_reload;
          else if (cnt_reg == 16'h0000)
            state_reg <= TMR_STOPPED;
          else
          begin
            cnt_reg <= cnt_reg - 16'h0001;
            // One-shot halts on the step that reaches zero
            if ((cnt_reg == 16'h0001) && !tif.periodic)
              state_reg <= TMR_STOPPED;
          end
        end
        default: state_reg <= TMR_STOPPED;
      endcase
    end
    else if (state_reg == TMR_COUNTING)
      pre_cnt_reg <= pre_top == 13'h0000 ? 13'h0000 : pre_cnt_reg - 13'h0001;
  end

  // first tick after a start only loads, so the counter divides by R+1
  always_ff @(posedge clk_in)
  begin
    if (!resetn_in)
      hold_reg <= 1'b0;
    else if (start)
      hold_reg <= 1'b1;
    else if (tick)
      hold_reg <= 1'b0;
  end

  // expiry pulse on the step from one to zero
  always_ff @(posedge clk_in)
  begin
    if (!resetn_in)
      expired_reg <= 1'b0;
    else
      expired_reg <= tick && !hold_reg && (cnt_reg == 16'h0001) && !tif.stop_now && !start;
  end

  // expiry only leaves the timer, nothing else is touched
  assign tif.expired = expired_reg;
  assign tif.running = state_reg == TMR_COUNTING;
  assign tif.value   = cnt_reg;

endmodule : irq_timer_core

// [src/irq_timer_fifo_status.sv]
// Interrupt flags, FIFO level status and timer register block
// Summary of operation
// - Flush write clears fill count, pointers and overflow error; count stays readable.
// - Overflow error stays set until a flush is requested.
// - Almost-full is one when 64 minus count is at most the watermark.
// - Almost-empty is one when count is at most the watermark.
// - Enabled almost-empty or almost-full raises the pin when status rises.
// - Events set their flags; enabled flags set the global interrupt bit and drive the pin.
// - Timer flag sets when the counter steps from one to zero.
// - Transmit-done flag sets when the transmitter starts the end-of-frame pattern.
// - CRC-done flag sets when CRC ready goes to one.
// - Receive-done flag sets at end of received data.
// - Idle flag sets when a command finishes and field returns to idle.
// - Almost-full and almost-empty flags set when their status becomes one.
// - Error flag sets while any error register bit is one.
// - Separate flags for card, foreign field, low RF, oscillator, watchdog.
// - Timer expiry only sets flags, never disturbs other processes.
// - Timer runs through a 12-bit prescaler with reload 0 to 4095.
// - Counter reloads from a 16-bit value; current value is readable.
// - Host can set and clear the timer flag by register write.
// - At zero the timer stops or restarts, as configured.
// - A running bit shows whether the timer counts.
// - Timer starts and stops on host bits; protocol events also start it in auto mode.
// - Stages divide by reload plus one; prescale 2P+1 or 2P+2.
`timescale 1ns/100ps
`include "irq_defines.svh"
module irq_timer_fifo_status
  import irq_pkg::*;
(
  input  wire logic        clk_in,
  input  wire logic        resetn_in,
  input  wire logic [7:0]  addr_in,
  input  wire logic [31:0] wr_data_in,
  input  wire logic        wr_en_in,
  input  wire logic        rd_en_in,
  output logic      [31:0] rd_data_out,
  input  wire logic        fifo_push_in,
  input  wire logic        fifo_pop_in,
  input  wire logic        tx_eof_start_in,
  input  wire logic        rx_end_in,
  input  wire logic        crc_ready_in,
  input  wire logic        cmd_done_in,
  input  wire logic [6:0]  err_bits_in,
  input  wire logic        card_det_in,
  input  wire logic        foreign_field_in,
  input  wire logic        rf_low_in,
  input  wire logic        osc_fail_in,
  input  wire logic        watchdog_in,
  input  wire logic        timer_proto_start_in,
  output logic             irq_out,
  output logic      [6:0]  fifo_fill_count_out,
  output logic             fifo_flush_out,
  output logic      [3:0]  command_out,
  output logic             timer_running_out
);

  timer_if tif ();

  irq_vec_t    irq_enable_reg;
  irq_vec_t    irq_flag_reg;
  irq_vec_t    hw_set;
  irq_vec_t    sw_set;
  irq_vec_t    sw_clr;
  logic [6:0]  count_reg;
  logic        overflow_reg;
  logic [5:0]  watermark_reg;
  logic [11:0] prescale_reg;
  logic        auto_reg;
  logic        periodic_reg;
  logic        even_reg;
  logic [15:0] reload_reg;
  logic [3:0]  command_reg;
  logic        flush_reg;
  logic        irq_reg;
  logic        running_reg;
  logic        a_full_prev_reg;
  logic        a_empty_prev_reg;
  logic        crc_prev_reg;
  logic [31:0] rd_data_reg;
  logic [31:0] rd_data_next;
  logic        almost_full_status;
  logic        almost_empty_status;
  logic        fifo_flush;
  logic        wr_flag;
  logic        wr_ctl;

  // Write decode
  assign wr_flag    = wr_en_in && (addr_in == `OFF_IRQ_FLAG);
  assign wr_ctl     = wr_en_in && (addr_in == `OFF_CONTROL);
  assign fifo_flush = wr_en_in && (addr_in == `OFF_FIFO_LEVEL) && wr_data_in[`FIFO_FLUSH];

  // Plain configuration registers
  always_ff @(posedge clk_in)
  begin
    if (!resetn_in)
    begin
      irq_enable_reg <= '0;
      watermark_reg  <= `WATERMARK_RST;
      prescale_reg   <= `PRESCALE_RST;
      auto_reg       <= 1'b0;
      periodic_reg   <= 1'b0;
      even_reg       <= 1'b0;
      reload_reg     <= `RELOAD_RST;
    end
    else if (wr_en_in)
    begin
      case (addr_in)
        `OFF_IRQ_EN:
          irq_enable_reg <= wr_data_in[`FLG_COUNT-1:0];
        `OFF_WATERMARK:
          watermark_reg <= wr_data_in[5:0];
        `OFF_TIMER_MODE:
        begin
          prescale_reg <= wr_data_in[11:0];
          auto_reg     <= wr_data_in[`TM_AUTO];
          periodic_reg <= wr_data_in[`TM_PERIODIC];
          even_reg     <= wr_data_in[`TM_EVEN];
        end
        `OFF_TIMER_RELOAD:
          reload_reg <= wr_data_in[15:0];
        default: ;
      endcase
    end
  end

  // Command field; engine completion returns it to idle
  always_ff @(posedge clk_in)
  begin
    if (!resetn_in)
      command_reg <= `CMD_IDLE;
    else if (wr_en_in && (addr_in == `OFF_COMMAND))
      command_reg <= wr_data_in[3:0];
    else if (cmd_done_in)
      command_reg <= `CMD_IDLE;
  end

  // Fill count; the data path itself lives elsewhere and only reports pushes and pops
  always_ff @(posedge clk_in)
  begin
    if (!resetn_in)
      count_reg <= 7'h00;
    else if (fifo_flush)
      count_reg <= 7'h00;
    else if (fifo_push_in && !fifo_pop_in && (count_reg != `FIFO_DEPTH))
      count_reg <= count_reg + 7'h01;
    else if (fifo_pop_in && !fifo_push_in && (count_reg != 7'h00))
      count_reg <= count_reg - 7'h01;
  end

  // Overflow: a push into a full buffer loses data
  always_ff @(posedge clk_in)
  begin
    if (!resetn_in)
      overflow_reg <= 1'b0;
    else if (fifo_flush)
      overflow_reg <= 1'b0;
    else if (fifo_push_in && !fifo_pop_in && (count_reg == `FIFO_DEPTH))
      overflow_reg <= 1'b1;
  end

  // Flush strobe toward the data path so pointers reset too
  always_ff @(posedge clk_in)
  begin
    if (!resetn_in)
      flush_reg <= 1'b0;
    else
      // pointers reset by the data path on this pulse
      flush_reg <= fifo_flush;
  end

  assign almost_full_status  = (`FIFO_DEPTH - count_reg) <= {1'b0, watermark_reg};
  assign almost_empty_status = count_reg <= {1'b0, watermark_reg};

  // Previous levels for rising edge detection
  always_ff @(posedge clk_in)
  begin
    if (!resetn_in)
    begin
      a_full_prev_reg  <= 1'b0;
      a_empty_prev_reg <= 1'b1;
      crc_prev_reg     <= 1'b0;
    end
    else
    begin
      a_full_prev_reg  <= almost_full_status;
      a_empty_prev_reg <= almost_empty_status;
      crc_prev_reg     <= crc_ready_in;
    end
  end

  // Hardware set conditions, one per flag
  always_comb
  begin
    hw_set = '0;
    hw_set[`FLG_TIMER]   = tif.expired;
    hw_set[`FLG_ERROR]   = overflow_reg || (|err_bits_in);
    hw_set[`FLG_A_EMPTY] = almost_empty_status && !a_empty_prev_reg;
    hw_set[`FLG_A_FULL]  = almost_full_status && !a_full_prev_reg;
    // finish while a command was active
    hw_set[`FLG_IDLE]    = cmd_done_in && (command_reg != `CMD_IDLE);
    hw_set[`FLG_RX]      = rx_end_in;
    hw_set[`FLG_TX]      = tx_eof_start_in;
    hw_set[`FLG_CRC]     = crc_ready_in && !crc_prev_reg;
    hw_set[`FLG_CARD]    = card_det_in;
    hw_set[`FLG_FOREIGN] = foreign_field_in;
    hw_set[`FLG_RF_LOW]  = rf_low_in;
    hw_set[`FLG_OSC]     = osc_fail_in;
    hw_set[`FLG_WDT]     = watchdog_in;
  end

  // top bit picks set or clear for the marked flags
  assign sw_set = wr_flag && wr_data_in[`FLG_SET_SEL] ? wr_data_in[`FLG_COUNT-1:0] : '0;
  assign sw_clr = wr_flag && !wr_data_in[`FLG_SET_SEL] ? wr_data_in[`FLG_COUNT-1:0] : '0;

  // Sticky flags; a hardware set in the clearing cycle is kept
  genvar gi;
  generate
    for (gi = 0; gi < `FLG_COUNT; gi = gi + 1)
    begin : g_flag
      always_ff @(posedge clk_in)
      begin
        if (!resetn_in)
          irq_flag_reg[gi] <= 1'b0;
        else if (hw_set[gi] || sw_set[gi])
          irq_flag_reg[gi] <= 1'b1;
        else if (sw_clr[gi])
          irq_flag_reg[gi] <= 1'b0;
      end
    end
  endgenerate

  // Interrupt pin, one cycle behind the flags
  always_ff @(posedge clk_in)
  begin
    if (!resetn_in)
      irq_reg <= 1'b0;
    else
      // any enabled flag drives the pin
      // watermark flags reach the pin through their enables
      // pin and global bit share this source
      irq_reg <= |(irq_flag_reg & irq_enable_reg);
  end

  // Timer controls; start and stop are single-cycle strobes
  // host start, stop and auto mode
  assign tif.start_now       = wr_ctl && wr_data_in[`CTL_START];
  assign tif.stop_now        = wr_ctl && wr_data_in[`CTL_STOP];
  assign tif.auto_evt        = timer_proto_start_in;
  assign tif.auto_en         = auto_reg;
  assign tif.periodic        = periodic_reg;
  assign tif.even_sel        = even_reg;
  assign tif.prescale_reload = prescale_reg;
  assign tif.counter_reload  = reload_reg;

  irq_timer_core u_timer (
    .clk_in    (clk_in),
    .resetn_in (resetn_in),
    .tif       (tif.core)
  );

  // Running status registered for the output pin
  always_ff @(posedge clk_in)
  begin
    if (!resetn_in)
      running_reg <= 1'b0;
    else
      running_reg <= tif.running;
  end

  // Read mux; unmapped addresses read zero
  always_comb
  begin
    rd_data_next = 32'h0000_0000;
    case (addr_in)
      `OFF_IRQ_EN:
        rd_data_next[`FLG_COUNT-1:0] = irq_enable_reg;
      `OFF_IRQ_FLAG:
        rd_data_next[`FLG_COUNT-1:0] = irq_flag_reg;
      `OFF_STATUS_ONE:
      begin
        rd_data_next[`ST_A_EMPTY] = almost_empty_status;
        rd_data_next[`ST_A_FULL]  = almost_full_status;
        rd_data_next[`ST_RUNNING] = tif.running;
        rd_data_next[`ST_IRQ]     = irq_reg;
        rd_data_next[`ST_CRC_RDY] = crc_ready_in;
      end
      `OFF_ERROR:
        rd_data_next[7:0] = {err_bits_in, overflow_reg};
      `OFF_FIFO_LEVEL:
        rd_data_next[6:0] = count_reg;
      `OFF_WATERMARK:
        rd_data_next[5:0] = watermark_reg;
      `OFF_TIMER_MODE:
      begin
        rd_data_next[11:0]         = prescale_reg;
        rd_data_next[`TM_AUTO]     = auto_reg;
        rd_data_next[`TM_PERIODIC] = periodic_reg;
        rd_data_next[`TM_EVEN]     = even_reg;
      end
      `OFF_TIMER_RELOAD:
        rd_data_next[15:0] = reload_reg;
      `OFF_TIMER_VALUE:
        rd_data_next[15:0] = tif.value;
      `OFF_COMMAND:
        rd_data_next[3:0] = command_reg;
      default: rd_data_next = 32'h0000_0000;
    endcase
  end

  // Read data valid only in the cycle after the strobe
  always_ff @(posedge clk_in)
  begin
    if (!resetn_in)
      rd_data_reg <= 32'h0000_0000;
    else if (rd_en_in)
      rd_data_reg <= rd_data_next;
    else
      rd_data_reg <= 32'h0000_0000;
  end

  // All outputs straight from flops
  assign rd_data_out         = rd_data_reg;
  assign irq_out             = irq_reg;
  assign fifo_fill_count_out = count_reg;
  assign fifo_flush_out      = flush_reg;
  assign command_out         = command_reg;
  assign timer_running_out   = running_reg;

endmodule : irq_timer_fifo_status

// [tb/irq_chk.sv]
// Port-level assertions for the irq, fifo status and timer block
`timescale 1ns/100ps
module irq_chk (
  input wire logic        clk_in,
  input wire logic        resetn_in,
  input wire logic [7:0]  addr_in,
  input wire logic [31:0] wr_data_in,
  input wire logic        wr_en_in,
  input wire logic        rd_en_in,
  input wire logic [31:0] rd_data_out,
  input wire logic        fifo_push_in,
  input wire logic        fifo_pop_in,
  input wire logic        cmd_done_in,
  input wire logic        fifo_flush_out,
  input wire logic [6:0]  fifo_fill_count_out,
  input wire logic [3:0]  command_out,
  input wire logic        timer_running_out
);
  default clocking cb @(posedge clk_in); endclocking
  default disable iff (!resetn_in);
  // Flush request, then a single-cycle pulse to the data path
  sequence flush_wr; wr_en_in && addr_in == 8'h10 && wr_data_in[7]; endsequence
  sequence flush_pulse; fifo_flush_out ##1 !fifo_flush_out; endsequence
  // Level writes also count as disturbing the fill count
  logic lvl_wr;
  assign lvl_wr = wr_en_in && addr_in == 8'h10;
  a_flush_pulse: assert property (flush_wr |=> flush_pulse)
    else $error("flush pulse missing");
  a_flush_count: assert property (flush_wr |=> fifo_fill_count_out == 7'h0)
    else $error("count not zero after flush");
  a_push_count: assert property (fifo_push_in && !fifo_pop_in && !lvl_wr && fifo_fill_count_out < 7'd64 |=>
    fifo_fill_count_out == $past(fifo_fill_count_out) + 7'h1) else $error("push did not add one");
  a_pop_count: assert property (fifo_pop_in && !fifo_push_in && !lvl_wr && fifo_fill_count_out > 7'h0 |=>
    fifo_fill_count_out == $past(fifo_fill_count_out) - 7'h1) else $error("pop did not take one");
  a_count_cap: assert property (fifo_fill_count_out <= 7'd64)
    else $error("count above depth");
  a_level_read: assert property (rd_en_in && addr_in == 8'h10 && !fifo_push_in && !fifo_pop_in |=>
    rd_data_out == {25'h0, fifo_fill_count_out}) else $error("level read wrong");
  a_read_idle: assert property (!rd_en_in |=> rd_data_out == 32'h0)
    else $error("read data outside read cycle");
  a_cmd_write: assert property (wr_en_in && addr_in == 8'h28 && !cmd_done_in |=>
    command_out == $past(wr_data_in[3:0])) else $error("command write lost");
  a_idle_return: assert property (cmd_done_in |=> command_out == 4'h0)
    else $error("command not idle after done");
  a_stop_halts: assert property (wr_en_in && addr_in == 8'h24 && wr_data_in[1] |->
    ##[1:3] !timer_running_out) else $error("timer kept running after stop");
  a_start_runs: assert property (wr_en_in && addr_in == 8'h24 && wr_data_in[1:0] == 2'b01 |->
    ##[1:3] timer_running_out) else $error("timer not running after start");
endmodule : irq_chk

// [tb/host_model.sv]
// Host side: register bus master and interrupt input
`timescale 1ns/100ps
module host_model (
  input  wire logic        clk_in,
  input  wire logic        irq_in,
  output logic      [7:0]  addr_out,
  output logic      [31:0] wr_data_out,
  output logic             wr_en_out,
  output logic             rd_en_out
);
  int irq_cycles;
  initial
  begin
    addr_out = 8'h00;
    wr_data_out = 32'h0;
    wr_en_out = 1'b0;
    rd_en_out = 1'b0;
    irq_cycles = 0;
  end
  // Time spent with the interrupt line up
  always @(posedge clk_in) if (irq_in) irq_cycles++;
  // host writes set, clear, start and stop
  task automatic wr(input logic [7:0] a, input logic [31:0] d);
    @(posedge clk_in);
    addr_out <= a;
    wr_data_out <= d;
    wr_en_out <= 1'b1;
    @(posedge clk_in);
    wr_en_out <= 1'b0;
  endtask : wr
  // One-cycle read strobe; data is taken by the bench monitor
  task automatic rd(input logic [7:0] a);
    @(posedge clk_in);
    addr_out <= a;
    rd_en_out <= 1'b1;
    @(posedge clk_in);
    rd_en_out <= 1'b0;
  endtask : rd
endmodule : host_model

// [tb/irq_timer_fifo_status_tb.sv]
// Self-checking bench for the irq, fifo status and timer block
`timescale 1ns/100ps
module irq_timer_fifo_status_tb;
  logic clk_in = 0, resetn_in = 0, fifo_push_in = 0, fifo_pop_in = 0, rd_d = 0;
  logic [9:0] ev = 0;
  logic [6:0] err_bits_in = 0;
  logic [7:0] addr_in;
  logic [31:0] wr_data_in, rd_data_out, ea;
  logic wr_en_in, rd_en_in, irq_out, fifo_flush_out, timer_running_out;
  logic [6:0] fifo_fill_count_out, c, w;
  logic [3:0] command_out;
  int n_fail = 0, n_tests = 0, n, k, p, per;
  int fb[9] = '{6, 5, 7, 8, 9, 10, 11, 12, 4};
  logic [31:0] exp_q[$];
  logic [7:0] adr_q[$];
  always #50 clk_in = ~clk_in;
  irq_timer_fifo_status irq_timer_fifo_status_i (.clk_in, .resetn_in, .addr_in, .wr_data_in, .wr_en_in,
    .rd_en_in, .rd_data_out, .fifo_push_in, .fifo_pop_in, .tx_eof_start_in(ev[0]), .rx_end_in(ev[1]),
    .crc_ready_in(ev[2]), .cmd_done_in(ev[8]), .err_bits_in, .card_det_in(ev[3]), .foreign_field_in(ev[4]),
    .rf_low_in(ev[5]), .osc_fail_in(ev[6]), .watchdog_in(ev[7]), .timer_proto_start_in(ev[9]), .irq_out,
    .fifo_fill_count_out, .fifo_flush_out, .command_out, .timer_running_out);
  host_model host_model_i (.clk_in, .irq_in(irq_out), .addr_out(addr_in), .wr_data_out(wr_data_in),
    .wr_en_out(wr_en_in), .rd_en_out(rd_en_in));
  task automatic chk(input string nm, input logic [31:0] e, input logic [31:0] s);
    n_tests++;
    if (s !== e)
    begin
      n_fail++;
      $display("[ERR] %s expected %h seen %h", nm, e, s);
    end
  endtask : chk
  task automatic summarize;
    $display("comparisons %0d mismatches %0d", n_tests, n_fail);
    if (n_fail == 0 && n_tests > 0)
      $display("== PASSED ==");
    else
      $display("== FAILED ==");
    $finish;
  endtask : summarize
  task automatic rd(input logic [7:0] a, input logic [31:0] e);
    exp_q.push_back(e);
    adr_q.push_back(a);
    host_model_i.rd(a);
  endtask : rd
  task automatic wr(input logic [7:0] a, input logic [31:0] d);
    host_model_i.wr(a, d);
  endtask : wr
  task automatic cyc(input int m);
    repeat (m) @(posedge clk_in);
    #1;
  endtask : cyc
  // One strobe held for m cycles on push, pop or an event line
  task automatic drive(input int s, input int m);
    @(posedge clk_in);
    if (s == 0) fifo_push_in <= 1'b1; else if (s == 1) fifo_pop_in <= 1'b1; else ev[s-2] <= 1'b1;
    repeat (m) @(posedge clk_in);
    fifo_push_in <= 1'b0;
    fifo_pop_in <= 1'b0;
    ev <= '0;
  endtask : drive
  // Read data is looked at only in the cycle after the strobe
  always @(posedge clk_in)
  begin
    if (rd_d) chk($sformatf("reg %h", adr_q.pop_front()), exp_q.pop_front(), rd_data_out);
    rd_d <= rd_en_in;
  end
  initial
  begin
    void'($urandom(32'he993));
    repeat (16) @(posedge clk_in);
    resetn_in <= 1'b1;
    foreach (fb[i]) rd(8'(4 * i), (i == 2) ? 32'h1 : (i == 5) ? 32'h8 : 32'h0);
    rd(8'h30, 32'h0);
    $display("reset values done");
    w = 7'($urandom_range(20, 4));
    n = $urandom_range(40, 1);
    k = $urandom_range(n, 0);
    c = 7'(n - k);
    wr(8'h14, 32'(w));
    drive(0, n);
    if (k > 0) drive(1, k);
    rd(8'h10, 32'(c));
    rd(8'h08, {30'h0, 7'd64 - c <= w, c <= w});
    wr(8'h04, 32'h1fff);
    drive(0, 64 - c);
    drive(0, 1);
    rd(8'h10, 32'd64);
    rd(8'h0c, 32'h1);
    rd(8'h08, 32'h2);
    rd(8'h04, 32'h8 | 32'h2);
    wr(8'h04, 32'h1fff);
    wr(8'h14, 32'(w));
    rd(8'h04, 32'h2);
    wr(8'h10, 32'h80);
    rd(8'h10, 32'h0);
    rd(8'h0c, 32'h0);
    rd(8'h04, 32'h6);
    wr(8'h04, 32'h1fff);
    wr(8'h00, 32'h4);
    drive(0, w + 1);
    drive(1, 1);
    cyc(3);
    chk("irq_out", 1, irq_out);
    rd(8'h08, 32'h11);
    wr(8'h00, 32'h0);
    cyc(2);
    chk("irq_out", 0, irq_out);
    wr(8'h10, 32'h80);
    wr(8'h04, 32'h1fff);
    $display("fifo status done");
    wr(8'h28, 32'h3);
    wr(8'h28, 32'h0);
    rd(8'h04, 32'h0);
    wr(8'h28, 32'h3);
    wr(8'h00, 32'h1fff);
    for (int i = 0; i < 9; i++)
    begin
      drive(i + 2, 1);
      rd(8'h04, 32'h1 << fb[i]);
      cyc(1);
      chk("irq_out", 1, irq_out);
      wr(8'h04, 32'h1 << fb[i]);
    end
    chk("command_out", 0, command_out);
    ea = 32'($urandom_range(127, 1));
    err_bits_in <= ea[6:0];
    cyc(2);
    rd(8'h0c, ea << 1);
    rd(8'h04, 32'h2);
    err_bits_in <= 7'h0;
    cyc(1);
    wr(8'h04, 32'h1fff);
    $display("event flags done");
    wr(8'h00, 32'h1);
    for (int t = 0; t < 3; t++)
    begin
      p = t + t / 2;
      n = t + 1;
      per = (2 * p + 1 + t % 2) * (n + 1);
      wr(8'h1c, 32'(n));
      wr(8'h18, 32'(p) | (32'(t % 2) << 14));
      wr(8'h24, 32'h1);
      k = 0;
      while (irq_out !== 1'b1 && k < 300)
      begin
        cyc(1);
        k++;
      end
      if (k == 300)
      begin
        n_fail++;
        summarize();
      end
      chk("timer period", 32'(per + 2), 32'(k));
      cyc(2);
      chk("timer_running_out", 0, timer_running_out);
      chk("fifo count", 0, fifo_fill_count_out);
      rd(8'h20, 32'h0);
      rd(8'h04, 32'h1);
      wr(8'h04, 32'h1);
    end
    wr(8'h04, 32'h80000001);
    rd(8'h04, 32'h1);
    wr(8'h04, 32'h1);
    rd(8'h04, 32'h0);
    wr(8'h18, 32'h2000);
    wr(8'h24, 32'h1);
    cyc(40);
    chk("timer_running_out", 1, timer_running_out);
    wr(8'h24, 32'h2);
    cyc(3);
    chk("timer_running_out", 0, timer_running_out);
    wr(8'h1c, 32'h100);
    drive(11, 1);
    cyc(3);
    chk("timer_running_out", 0, timer_running_out);
    wr(8'h18, 32'h1000);
    drive(11, 1);
    cyc(3);
    chk("timer_running_out", 1, timer_running_out);
    wr(8'h24, 32'h3);
    $display("timer done");
    cyc(4);
    summarize();
  end
endmodule : irq_timer_fifo_status_tb
bind irq_timer_fifo_status irq_chk irq_chk_i (.clk_in, .resetn_in, .addr_in, .wr_data_in, .wr_en_in,
  .rd_en_in, .rd_data_out, .fifo_push_in, .fifo_pop_in, .cmd_done_in, .fifo_flush_out,
  .fifo_fill_count_out, .command_out, .timer_running_out);
